// ===== design/pin_power_down_hold.sv
// Summary of operation
// - With the option on, a high level on the sleep pin freezes the device in its hold state.
// - On entry all internal states and output values are captured and held unchanged.
// - An output that was high-impedance at entry stays high-impedance throughout.
// - While asleep every input except the sleep pin and the reset is ignored.
// - Input and I/O hold latches keep the last pin levels during sleep.
// - The feature is chosen only by a configuration option; when off the pin is ordinary logic.
// - With the option on, the sleep pin never feeds the logic array.
// - Sampling of inputs, enables and clocks stops within 12 ns of the pin rising.
// - Within 1 us of the pin falling, inputs are accepted again and outputs are valid.
module pin_power_down_hold
#(
   parameter int N_IN  = 8,   // Input pins held
   parameter int N_OUT = 8    // Output pins held
) (
   input  wire logic             clk_i,            // Core clock, 250 MHz
   input  wire logic             rstn_i,           // Async reset, active low
   input  wire logic             cfg_pd_en_i,      // Option strap, caught after reset
   input  wire logic             sleep_hold_pin_i, // Sleep pin from the board
   input  wire logic [N_IN-1:0]  pin_in_i,         // Input and I/O pin levels
   input  wire logic [N_OUT-1:0] core_out_i,       // Output data from the logic
   input  wire logic [N_OUT-1:0] core_oe_i,        // Output enables from the logic
   output logic      [N_IN-1:0]  core_in_o,        // Held pin levels to the logic
   output logic                  core_run_o,       // High: logic may clock and update
   output logic                  plain_pin_o,      // Sleep pin as ordinary logic input
   output logic      [N_OUT-1:0] pad_out_o,        // Data to the pads
   output logic      [N_OUT-1:0] pad_oe_o,         // Pad enables, high drives
   output logic                  asleep_o          // Device frozen
);
   import sleep_hold_pkg::*;

   // Rise sequence already spends two of the stop cycles in the synchroniser
   localparam int STOP_A = STOP_CYC - 2;
   localparam int WAKE_A = WAKE_CYC;

   // Synchronisers: the first stage is read only by the second
   logic              pd_meta;
   logic              pd_sync;
   logic [N_IN-1:0]   in_meta;
   logic [N_IN-1:0]   in_sync;

   // Configuration and control state
   logic              cfg_en;
   logic              cfg_loaded;
   hold_state_t       state;
   logic              run;
   logic              next_cfg_en;
   logic              next_cfg_loaded;
   hold_state_t       next_state;
   logic              next_run;
   logic              next_plain;
   logic              load;

   // Two-stage synchronisers for the sleep pin and the input pins
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pd_meta <= 1'b0;
         pd_sync <= 1'b0;
         in_meta <= '0;
         in_sync <= '0;
      end
      else
      begin
         pd_meta <= sleep_hold_pin_i;
         pd_sync <= pd_meta;
         in_meta <= pin_in_i;
         in_sync <= in_meta;
      end
   end

   // Option caught once at the first edge after release, never under reset
   always_comb
   begin
      next_cfg_loaded = 1'b1;
      next_cfg_en     = cfg_loaded ? cfg_en : cfg_pd_en_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cfg_loaded <= 1'b0;
         cfg_en     <= RST_CFG_EN;
      end
      else
      begin
         cfg_loaded <= next_cfg_loaded;
         cfg_en     <= next_cfg_en;
      end
   end

   // Sleep state machine; pin path is two sync stages plus this register
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_RUN:
            if (cfg_loaded && cfg_en && pd_sync)
               next_state = ST_SLEEP;
         ST_SLEEP:
            if (!pd_sync || !cfg_en)
               next_state = ST_RUN;
      endcase
      next_run   = (next_state == ST_RUN);
      // With the option on the pin is a control only, never logic data
      next_plain = cfg_en ? 1'b0 : pd_sync;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state       <= ST_RUN;
         run         <= RST_RUN;
         plain_pin_o <= 1'b0;
         asleep_o    <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         run         <= next_run;
         plain_pin_o <= next_plain;
         asleep_o    <= !next_run;
      end
   end

   assign core_run_o = run;

   // Banks load only while running; the decision is the same next state that
   // freezes the logic, so inputs and outputs stop on the same edge
   assign load = next_run;

   // Input hold latches keep the pins' last levels for the logic
   hold_bank #(.W(N_IN)) u_in_hold (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .load_i (load),
      .d_i    (in_sync),
      .q_o    (core_in_o)
   );

   // Output data held, so registered and combinational outputs stay valid
   hold_bank #(.W(N_OUT)) u_out_hold (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .load_i (load),
      .d_i    (core_out_i),
      .q_o    (pad_out_o)
   );

   // Enables held too: a pad off at entry stays off until wake
   hold_bank #(.W(N_OUT)) u_oe_hold (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .load_i (load),
      .d_i    (core_oe_i),
      .q_o    (pad_oe_o)
   );

   // Pin rise held long enough to pass the synchroniser
   sequence s_pin_rise;
      $rose(sleep_hold_pin_i) && cfg_en && cfg_loaded ##1 sleep_hold_pin_i [*2];
   endsequence

   sequence s_pin_fall;
      $fell(sleep_hold_pin_i) ##1 !sleep_hold_pin_i [*2];
   endsequence

   property p_enter_sleep;
      @(posedge clk_i) disable iff (!rstn_i)
      (cfg_en && cfg_loaded && pd_sync && state == ST_RUN) |=> asleep_o && !core_run_o;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered");

   property p_out_held;
      @(posedge clk_i) disable iff (!rstn_i)
      (asleep_o && $past(asleep_o)) |-> $stable(pad_out_o);
   endproperty
   a_out_held: assert property (p_out_held) else $error("output data moved in sleep");

   property p_hiz_held;
      @(posedge clk_i) disable iff (!rstn_i)
      (asleep_o && $past(asleep_o)) |-> $stable(pad_oe_o);
   endproperty
   a_hiz_held: assert property (p_hiz_held) else $error("pad enable moved in sleep");

   property p_in_blocked;
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(asleep_o) |=> (core_in_o == $past(core_in_o, 2)) throughout asleep_o [*1];
   endproperty
   a_in_blocked: assert property (p_in_blocked) else $error("input passed in sleep");

   property p_keep_level;
      @(posedge clk_i) disable iff (!rstn_i)
      asleep_o && $past(asleep_o) |-> $stable(core_in_o);
   endproperty
   a_keep_level: assert property (p_keep_level) else $error("hold latch lost level");

   property p_plain_pin;
      @(posedge clk_i) disable iff (!rstn_i)
      (!cfg_en && cfg_loaded) |=> !asleep_o && (plain_pin_o == $past(pd_sync));
   endproperty
   a_plain_pin: assert property (p_plain_pin) else $error("pin not ordinary when off");

   property p_no_array;
      @(posedge clk_i) disable iff (!rstn_i)
      $past(cfg_en) |-> !plain_pin_o;
   endproperty
   a_no_array: assert property (p_no_array) else $error("sleep pin fed the logic");

   property p_stop_time;
      @(posedge clk_i) disable iff (!rstn_i)
      s_pin_rise |-> ##[0:STOP_A] !core_run_o;
   endproperty
   a_stop_time: assert property (p_stop_time) else $error("sampling not stopped");

   property p_wake_time;
      @(posedge clk_i) disable iff (!rstn_i)
      s_pin_fall |-> ##[0:WAKE_A] core_run_o;
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("no wake in time");
endmodule // pin_power_down_hold

// ===== common/sleep_hold_pkg.sv
package sleep_hold_pkg;
   // Clock period and the documented times, each in its own unit
   localparam int CLK_PS  = 4000;
   localparam int LEAD_NS = 7;     // Inputs valid before the pin rises
   localparam int STOP_NS = 12;    // Latest stop of sampling after rise
   localparam int WAKE_US = 1;     // Latest return after the pin falls

   // Cycle counts: least time rounds up, longest rounds down
   localparam int LEAD_CYC = (LEAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int STOP_CYC = (STOP_NS * 1000) / CLK_PS;
   localparam int WAKE_CYC = (WAKE_US * 1000000) / CLK_PS;

   // Reset values
   localparam logic RST_CFG_EN = 1'b0;
   localparam logic RST_RUN    = 1'b1;

   // Run or frozen
   typedef enum logic {ST_RUN, ST_SLEEP} hold_state_t;
endpackage

// ===== design/hold_bank.sv
// Bank of hold registers; the stored word comes out of a flip-flop
module hold_bank #(
   parameter int          W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk_i,   // Core clock
   input  wire logic         rstn_i,  // Async reset, active low
   input  wire logic         load_i,  // Capture d_i this edge
   input  wire logic [W-1:0] d_i,     // New word
   output logic      [W-1:0] q_o      // Held word
);
   logic [W-1:0] next_q;

   // Keep the old word unless told to load
   always_comb
   begin
      next_q = load_i ? d_i : q_o;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         q_o <= RST;
      else
         q_o <= next_q;
   end
endmodule // hold_bank

// ===== bench/sleep_driver.sv
// Board logic that owns the sleep pin
module sleep_driver
   import sleep_hold_pkg::*;
(
   input  wire logic clk_i,  // Core clock
   input  wire logic want_i, // Bench asks for sleep
   output logic      pin_o   // Sleep pin to the device
);
   timeunit 1ns;
   timeprecision 1ps;

   int lead = 0;

   // Pin rises only once want_i has been held high for the lead time;
   // unknown until the first edge, which reset covers
   always @(posedge clk_i)
   begin
      lead  <= want_i ? lead + 1 : 0;
      pin_o <= #1 want_i && (lead >= LEAD_CYC);
   end
endmodule // sleep_driver

// ===== bench/pin_power_down_hold_bench.sv
module pin_power_down_hold_bench
   import sleep_hold_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {int id; logic [7:0] e;} note_t;
   logic        clk_i, rstn_i, cfg_pd_en_i, want, sleep_pin, core_run_o, plain_pin_o, asleep_o;
   logic [7:0]  pin_in_i, core_out_i, core_oe_i, core_in_o, pad_out_o, pad_oe_o;
   logic [7:0]  s_in, s_out, s_oe, seen;
   int          fails = 0, checked = 0;
   int unsigned seed_v;
   note_t       exp_q[$];
   note_t       nt;
   event        look;
   string       nm[4] = '{"core_in_o", "pad_out_o", "pad_oe_o", "asleep_run_plain"};

   pin_power_down_hold pin_power_down_hold_i (.clk_i, .rstn_i, .cfg_pd_en_i,
      .sleep_hold_pin_i(sleep_pin), .pin_in_i, .core_out_i, .core_oe_i, .core_in_o,
      .core_run_o, .plain_pin_o, .pad_out_o, .pad_oe_o, .asleep_o);
   sleep_driver sleep_driver_i (.clk_i, .want_i(want), .pin_o(sleep_pin));

   // 250 MHz core clock
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task note(input int id, input logic [7:0] e);
      exp_q.push_back('{id, e});
      ->look;
   endtask

   task summarize();
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Bounded wait on the frozen flag; running out ends the run
   task wait_sleep(input logic v, input int lim);
      int k;
      k = 0;
      while (asleep_o !== v && k < lim)
      begin
         cyc(1);
         k++;
      end
      if (asleep_o !== v)
      begin
         fails++;
         $display("[ERR] asleep_o exp %h seen %h", v, asleep_o);
         summarize();
      end
   endtask

   task rnd();
      pin_in_i   = 8'($urandom);
      core_out_i = 8'($urandom);
      core_oe_i  = 8'($urandom);
   endtask

   // Reset with the option strap, traffic, one sleep request and one release; the device sleeps only when en is set
   task run(input logic en);
      rstn_i      = 1'b0;
      cfg_pd_en_i = en;
      cyc(5);
      note(3, 8'h02);
      note(1, 8'h00);
      rstn_i = 1'b1;
      repeat (3)
      begin
         rnd();
         cyc(3);
         note(0, pin_in_i);
         note(1, core_out_i);
         note(2, core_oe_i);
      end
      s_in  = pin_in_i;
      s_out = core_out_i;
      s_oe  = core_oe_i;
      want  = 1'b1;
      repeat (LEAD_CYC + 2) if (sleep_pin !== 1'b1) cyc(1);
      if (en)
         wait_sleep(1'b1, STOP_CYC);
      else
         cyc(3);
      note(3, en ? 8'h04 : 8'h03);
      // Frozen copies must ignore every input change while asleep
      repeat (8)
      begin
         rnd();
         cyc(3);
         note(0, en ? s_in : pin_in_i);
         note(1, en ? s_out : core_out_i);
         note(2, en ? s_oe : core_oe_i);
      end
      want = 1'b0;
      repeat (3) if (sleep_pin !== 1'b0) cyc(1);
      wait_sleep(1'b0, WAKE_CYC);
      rnd();
      cyc(3);
      note(0, pin_in_i);
      note(1, core_out_i);
      note(2, core_oe_i);
      note(3, 8'h02);
   endtask

   // Every queued note, oldest first, against what the outputs show now
   always @(look)
      while (exp_q.size() > 0)
      begin
         nt = exp_q.pop_front();
         case (nt.id)
            0:       seen = core_in_o;
            1:       seen = pad_out_o;
            2:       seen = pad_oe_o;
            default: seen = {5'h00, asleep_o, core_run_o, plain_pin_o};
         endcase
         checked++;
         if (seen !== nt.e)
         begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm[nt.id], nt.e, seen);
         end
      end

   initial
   begin
      seed_v      = $urandom(49);
      rstn_i      = 1'b0;
      cfg_pd_en_i = 1'b0;
      want        = 1'b0;
      pin_in_i    = 8'h00;
      core_out_i  = 8'h00;
      core_oe_i   = 8'h00;
      run(1'b0);
      run(1'b1);
      ->look;
      #1;
      summarize();
   end
endmodule // pin_power_down_hold_bench
